//--- logic/sqg_pkg.sv
// Shared constants and types of the symbol quality output gate
package sqg_pkg;

    // ****************************************
    // Widths and metric indices
    // ****************************************
    localparam int LIN_N    = 10;  // Linear metric count
    localparam int DPM_N    = 7;   // Part-mark metric count
    localparam int GRADE_W  = 2;   // Grade code width
    localparam int LIN_OVERALL  = 0;
    localparam int LIN_EDGE     = 1;
    localparam int LIN_DECODE   = 2;
    localparam int LIN_CONTRAST = 3;
    localparam int LIN_MIN_REFL = 4;
    localparam int LIN_MIN_EC   = 5;
    localparam int LIN_MODUL    = 6;
    localparam int LIN_DEFECTS  = 7;
    localparam int LIN_DECODAB  = 8;
    localparam int LIN_QUIET    = 9;
    localparam int DPM_OVERALL  = 0;
    localparam int DPM_CELL_CON = 1;
    localparam int DPM_CELL_MOD = 2;
    localparam int DPM_FPD      = 3;
    localparam int DPM_AXIAL    = 4;
    localparam int DPM_GRID     = 5;
    localparam int DPM_UEC      = 6;

    // ****************************************
    // Grade codes, reset values, limits
    // ****************************************
    localparam logic [1:0]  GRADE_D     = 2'h0;
    localparam logic [1:0]  GRADE_C     = 2'h1;
    localparam logic [1:0]  GRADE_B     = 2'h2;
    localparam logic [1:0]  GRADE_A     = 2'h3;
    localparam logic [19:0] LIN_THR_RST = 20'ha_aaaa;
    localparam logic [13:0] DPM_THR_RST = 14'h2aaa;
    localparam logic [9:0]  LIN_EN_RST  = 10'h000;
    localparam logic [6:0]  DPM_EN_RST  = 7'h00;
    localparam logic [7:0]  PPE_MIN_LIN = 8'h28;  // 4.0 px, tenths
    localparam logic [7:0]  PPE_MIN_DPM = 8'h3c;  // 6.0 px, tenths

    // ****************************************
    // Register map, byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_LIN_EN   = 8'h04;
    localparam logic [7:0] ADDR_LIN_THR  = 8'h08;
    localparam logic [7:0] ADDR_DPM_EN   = 8'h0c;
    localparam logic [7:0] ADDR_DPM_THR  = 8'h10;
    localparam logic [7:0] ADDR_RESULT   = 8'h14;
    localparam logic [7:0] ADDR_INT_STAT = 8'h18;
    localparam logic [7:0] ADDR_INT_MASK = 8'h1c;
    localparam int CTRL_DFLT_BIT  = 0;   // Write 1: restore defaults
    localparam int RES_QUAL_BIT   = 16;
    localparam int RES_SET_BIT    = 17;
    localparam int EV_FAIL        = 0;   // Graded read drove output
    localparam int EV_PASS        = 1;   // Graded read, no failure
    localparam int EV_SKIP        = 2;   // Read not eligible to grade
    localparam int EV_N           = 3;

    // ****************************************
    // Module state
    // ****************************************
    typedef struct packed {
        logic [LIN_N-1:0]         lin_en;
        logic [LIN_N*GRADE_W-1:0] lin_thr;
        logic [DPM_N-1:0]         dpm_en;
        logic [DPM_N*GRADE_W-1:0] dpm_thr;
        logic                     qual;
        logic                     last_dpm;
        logic [LIN_N-1:0]         fail;
        logic [EV_N-1:0]          int_stat;
        logic [EV_N-1:0]          int_mask;
        logic [31:0]              rdata;
    } sqg_state_t;

endpackage

//--- logic/sqg_grade_cmp.sv
// Per-metric grade against threshold comparator bank
`timescale 1ns/1ps
`default_nettype none
module sqg_grade_cmp
    import sqg_pkg::*;
(
    // Per-metric inputs, metric i at bits [2i+1:2i] of grade and thr, bit i of en
    input  wire logic [LIN_N*GRADE_W-1:0] grade,
    input  wire logic [LIN_N*GRADE_W-1:0] thr,
    input  wire logic [LIN_N-1:0]         en,
    // Enabled metrics graded worse than their threshold
    output logic      [LIN_N-1:0]         below
);

    // Higher code is better, so worse means numerically smaller
    function automatic logic worse(input logic [1:0] g,
                                   input logic [1:0] t);
        worse = (g < t);
    endfunction

    // One comparator per metric
    for (genvar i = 0; i < LIN_N; i++) begin : g_cmp
        assign below[i] = en[i] &
            worse(grade[GRADE_W*i +: GRADE_W], thr[GRADE_W*i +: GRADE_W]);
    end

endmodule
`default_nettype wire

//--- logic/sqg_gate.sv
// Symbol quality output gate: configuration, grading and interrupt
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sqg_gate
    import sqg_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // Register port
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    // Graded read from the grading engine
    input  wire logic                     grade_vld,
    input  wire logic                     grade_dpm,
    input  wire logic                     grade_sym_ok,
    input  wire logic [7:0]               grade_ppe,
    input  wire logic [LIN_N*GRADE_W-1:0] grade_vec,
    // Outputs to the monitoring equipment and the processor
    output logic                          qual_out,
    output logic      [LIN_N-1:0]         fail_vec,
    output logic                          irq
);

    // ****************************************
    // State and derived terms
    // ****************************************
    sqg_state_t s_r;
    sqg_state_t s_nxt;

    logic [LIN_N*GRADE_W-1:0] cmp_thr;
    logic [LIN_N-1:0]         cmp_en;
    logic [LIN_N-1:0]         below;
    logic                     eligible;
    logic                     graded;
    logic                     skipped;
    logic                     dflt_load;
    logic [EV_N-1:0]          ev_set;

    // Address compare for write decode; reads decode with a case on reg_addr
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] r);
        hit = (a == r);
    endfunction

    // ****************************************
    // Metric set selection and eligibility
    // ****************************************

    // Part-mark set uses the low seven slots, upper slots disabled
    always_comb begin
        if (grade_dpm) begin
            cmp_thr = {{(LIN_N-DPM_N)*GRADE_W{1'b0}}, s_r.dpm_thr};
            cmp_en  = {{(LIN_N-DPM_N){1'b0}}, s_r.dpm_en};
        end else begin
            cmp_thr = s_r.lin_thr;
            cmp_en  = s_r.lin_en;
        end
    end

    // Resolution floor differs per set
    always_comb begin
        if (grade_dpm) begin
            eligible = grade_sym_ok && (grade_ppe >= PPE_MIN_DPM);
        end else begin
            eligible = grade_sym_ok && (grade_ppe >= PPE_MIN_LIN);
        end
    end

    assign graded    = grade_vld && eligible;
    assign skipped   = grade_vld && !eligible;
    assign dflt_load = reg_wr && hit(reg_addr, ADDR_CTRL) &&
                       reg_wdata[CTRL_DFLT_BIT];

    // Comparator bank
    sqg_grade_cmp u_cmp (
        .grade (grade_vec),
        .thr   (cmp_thr),
        .en    (cmp_en),
        .below (below)
    );

    // Events that set sticky status
    always_comb begin
        ev_set          = '0;
        ev_set[EV_FAIL] = graded && (|below);
        ev_set[EV_PASS] = graded && !(|below);
        ev_set[EV_SKIP] = skipped;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = 32'h0000_0000;

        // Register writes
        if (reg_wr) begin
            if (hit(reg_addr, ADDR_LIN_EN)) begin
                s_nxt.lin_en = reg_wdata[LIN_N-1:0];
            end
            if (hit(reg_addr, ADDR_LIN_THR)) begin
                s_nxt.lin_thr = reg_wdata[LIN_N*GRADE_W-1:0];
            end
            if (hit(reg_addr, ADDR_DPM_EN)) begin
                s_nxt.dpm_en = reg_wdata[DPM_N-1:0];
            end
            if (hit(reg_addr, ADDR_DPM_THR)) begin
                s_nxt.dpm_thr = reg_wdata[DPM_N*GRADE_W-1:0];
            end
            if (hit(reg_addr, ADDR_INT_MASK)) begin
                s_nxt.int_mask = reg_wdata[EV_N-1:0];
            end
            if (hit(reg_addr, ADDR_INT_STAT)) begin
                s_nxt.int_stat = s_r.int_stat & ~reg_wdata[EV_N-1:0];
            end
        end

        // Default configuration command overrides same-cycle writes
        if (dflt_load) begin
            s_nxt.lin_en  = LIN_EN_RST;
            s_nxt.dpm_en  = DPM_EN_RST;
            s_nxt.lin_thr = LIN_THR_RST;
            s_nxt.dpm_thr = DPM_THR_RST;
        end

        // One evaluation per eligible graded read; held until the next
        if (graded) begin
            s_nxt.qual     = |below;
            s_nxt.fail     = below;
            s_nxt.last_dpm = grade_dpm;
        end

        // New events win over a same-cycle clear
        s_nxt.int_stat = s_nxt.int_stat | ev_set;

        // Read data, valid in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_LIN_EN:   s_nxt.rdata[LIN_N-1:0] = s_r.lin_en;
                ADDR_LIN_THR:  s_nxt.rdata[LIN_N*GRADE_W-1:0] = s_r.lin_thr;
                ADDR_DPM_EN:   s_nxt.rdata[DPM_N-1:0] = s_r.dpm_en;
                ADDR_DPM_THR:  s_nxt.rdata[DPM_N*GRADE_W-1:0] = s_r.dpm_thr;
                ADDR_RESULT: begin
                    s_nxt.rdata[LIN_N-1:0]    = s_r.fail;
                    s_nxt.rdata[RES_QUAL_BIT] = s_r.qual;
                    s_nxt.rdata[RES_SET_BIT]  = s_r.last_dpm;
                end
                ADDR_INT_STAT: s_nxt.rdata[EV_N-1:0] = s_r.int_stat;
                ADDR_INT_MASK: s_nxt.rdata[EV_N-1:0] = s_r.int_mask;
                default:       s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_r          <= '0;
            s_r.lin_en   <= LIN_EN_RST;
            s_r.dpm_en   <= DPM_EN_RST;
            s_r.lin_thr  <= LIN_THR_RST;
            s_r.dpm_thr  <= DPM_THR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state
    assign reg_rdata = s_r.rdata;
    assign qual_out  = s_r.qual;
    assign fail_vec  = s_r.fail;
    assign irq       = |(s_r.int_stat & s_r.int_mask);

    // ****************************************
    // Assertions
    // ****************************************

    // Failing enabled metric drives the output on the next edge
    out_fail_a: assert property (@(posedge mclk) disable iff (reset)
        graded && (|(cmp_en & below)) |=> qual_out && fail_vec != '0)
        else $error("enabled failing metric did not drive output");

    // Clean read releases the output
    out_pass_a: assert property (@(posedge mclk) disable iff (reset)
        graded && !(|below) |=> !qual_out && fail_vec == '0)
        else $error("output held after a clean graded read");

    // Output only moves on an eligible graded read
    out_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !graded |=> $stable(qual_out))
        else $error("output changed without a graded read");

    // Grade A on a metric never counts as below threshold
    grade_a_a: assert property (@(posedge mclk) disable iff (reset)
        graded && grade_vec[1:0] == GRADE_A |=> !fail_vec[0])
        else $error("grade A reported below threshold");

    // Default load gives grade B thresholds everywhere
    dflt_thr_a: assert property (@(posedge mclk) disable iff (reset)
        dflt_load |=> s_r.lin_thr == LIN_THR_RST &&
                      s_r.dpm_thr == DPM_THR_RST)
        else $error("default thresholds not grade B");

    // Default load disables all metrics, so reads stay clean
    dflt_en_a: assert property (@(posedge mclk) disable iff (reset)
        dflt_load ##1 (!reg_wr && graded) |=> !qual_out)
        else $error("disabled metric drove output");

    // Quiet zone is the tenth linear slot
    lin_order_a: assert property (@(posedge mclk) disable iff (reset)
        reg_wr && hit(reg_addr, ADDR_LIN_EN) && !dflt_load |=>
        s_r.lin_en[LIN_QUIET] == $past(reg_wdata[LIN_QUIET]))
        else $error("linear enable order broken");

    // Part-mark reads never flag the unused upper slots
    dpm_order_a: assert property (@(posedge mclk) disable iff (reset)
        graded && grade_dpm |=> fail_vec[LIN_N-1:DPM_N] == '0)
        else $error("part-mark read flagged linear-only slot");

    // Low resolution part-mark read is skipped
    dpm_res_a: assert property (@(posedge mclk) disable iff (reset)
        grade_vld && grade_dpm && grade_ppe < PPE_MIN_DPM |=>
        $stable(qual_out) && s_r.int_stat[EV_SKIP])
        else $error("part-mark read under 6.0 px was graded");

    // Low resolution linear read is skipped
    lin_res_a: assert property (@(posedge mclk) disable iff (reset)
        grade_vld && !grade_dpm && grade_ppe < PPE_MIN_LIN |=>
        $stable(qual_out) && s_r.int_stat[EV_SKIP])
        else $error("linear read under 4.0 px was graded");

    // ****************************************
    // Reset, register and event checks
    // ****************************************

    // Reset clears every output the equipment and processor see
    rst_out_a: assert property (@(posedge mclk)
        reset |=> !qual_out && fail_vec == '0 && !irq && reg_rdata == '0)
        else $error("outputs not cleared by reset");

    // Reset restores grade B thresholds and disabled metrics
    rst_cfg_a: assert property (@(posedge mclk)
        reset |=> s_r.lin_thr == LIN_THR_RST && s_r.dpm_thr == DPM_THR_RST &&
                  s_r.lin_en == LIN_EN_RST && s_r.dpm_en == DPM_EN_RST)
        else $error("reset configuration wrong");

    // Enable read shows the enables, upper bits zero
    rd_en_a: assert property (@(posedge mclk) disable iff (reset)
        reg_rd && reg_addr == ADDR_LIN_EN |=>
        reg_rdata == {{(32-LIN_N){1'b0}}, $past(s_r.lin_en)})
        else $error("enable read data wrong");

    // Threshold read shows the two-bit codes, upper bits zero
    rd_thr_a: assert property (@(posedge mclk) disable iff (reset)
        reg_rd && reg_addr == ADDR_LIN_THR |=>
        reg_rdata == {{(32-LIN_N*GRADE_W){1'b0}}, $past(s_r.lin_thr)})
        else $error("threshold read data wrong");

    // Part-mark threshold write lands as written
    dpm_thr_wr_a: assert property (@(posedge mclk) disable iff (reset)
        reg_wr && hit(reg_addr, ADDR_DPM_THR) |=>
        s_r.dpm_thr == $past(reg_wdata[DPM_N*GRADE_W-1:0]))
        else $error("part-mark threshold write lost");

    // Threshold D never fails: no code is below it
    thr_d_a: assert property (@(posedge mclk) disable iff (reset)
        graded && !grade_dpm && s_r.lin_thr[1:0] == GRADE_D |=>
        !fail_vec[LIN_OVERALL])
        else $error("failure reported against threshold D");

    // Grade D fails an enabled metric with any higher threshold
    grade_d_a: assert property (@(posedge mclk) disable iff (reset)
        graded && !grade_dpm && s_r.lin_en[LIN_OVERALL] &&
        grade_vec[1:0] == GRADE_D && s_r.lin_thr[1:0] != GRADE_D |=>
        fail_vec[LIN_OVERALL])
        else $error("grade D passed a higher threshold");

    // Disabled metrics never drive the output
    dis_quiet_a: assert property (@(posedge mclk) disable iff (reset)
        graded && cmp_en == '0 |=> !qual_out && fail_vec == '0)
        else $error("output driven with every metric disabled");

    // Quiet zone is judged in the tenth linear slot
    quiet_slot_a: assert property (@(posedge mclk) disable iff (reset)
        graded && !grade_dpm && s_r.lin_en[LIN_QUIET] &&
        grade_vec[GRADE_W*LIN_QUIET +: GRADE_W] <
        s_r.lin_thr[GRADE_W*LIN_QUIET +: GRADE_W] |=>
        fail_vec[LIN_QUIET] && qual_out)
        else $error("quiet zone slot not judged");

    // Unused error correction is judged in the seventh part-mark slot
    uec_slot_a: assert property (@(posedge mclk) disable iff (reset)
        graded && grade_dpm && s_r.dpm_en[DPM_UEC] &&
        grade_vec[GRADE_W*DPM_UEC +: GRADE_W] <
        s_r.dpm_thr[GRADE_W*DPM_UEC +: GRADE_W] |=>
        fail_vec[DPM_UEC] && qual_out)
        else $error("unused error correction slot not judged");

    // Unsupported symbology is skipped and flagged
    sym_skip_a: assert property (@(posedge mclk) disable iff (reset)
        grade_vld && !grade_sym_ok |=>
        $stable(fail_vec) && s_r.int_stat[EV_SKIP])
        else $error("unsupported symbology was graded");

    // Failure flags only move on an eligible graded read
    fail_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !graded |=> $stable(fail_vec))
        else $error("failure flags changed without a graded read");

    // A failing read sets its status even beside a clear
    ev_fail_a: assert property (@(posedge mclk) disable iff (reset)
        graded && (|below) |=> s_r.int_stat[EV_FAIL])
        else $error("failing read did not set status");

    // A clean read sets its status even beside a clear
    ev_pass_a: assert property (@(posedge mclk) disable iff (reset)
        graded && !(|below) |=> s_r.int_stat[EV_PASS])
        else $error("clean read did not set status");

    // Result read reports the output level of the last read
    res_qual_a: assert property (@(posedge mclk) disable iff (reset)
        reg_rd && reg_addr == ADDR_RESULT |=>
        reg_rdata[RES_QUAL_BIT] == $past(qual_out))
        else $error("result read lost the output level");

    // Default load turns every metric off
    dflt_off_a: assert property (@(posedge mclk) disable iff (reset)
        dflt_load |=> s_r.lin_en == LIN_EN_RST && s_r.dpm_en == DPM_EN_RST)
        else $error("default load left a metric enabled");

    // Thresholds change only through a register write
    cfg_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !reg_wr |=> $stable(s_r.lin_thr) && $stable(s_r.dpm_thr))
        else $error("thresholds changed without a write");

endmodule
`default_nettype wire

//--- verif/sqg_monitor.sv
// Model of the equipment that watches the quality output level
`timescale 1ns/1ps
`default_nettype none
module sqg_monitor (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Quality level as seen at the equipment
    input  wire logic        qual_out,
    // Number of alarms seen
    output logic      [15:0] alarm_cnt
);
    logic qual_r;

    // Count each rise of the level as one alarm
    always_ff @(posedge mclk) begin
        if (reset) begin
            qual_r    <= 1'b0;
            alarm_cnt <= 16'h0000;
        end else begin
            qual_r <= qual_out;
            if (qual_out && !qual_r) begin
                alarm_cnt <= alarm_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/symbol_quality_output_gate_bench.sv
// Self-checking bench of the symbol quality output gate
`timescale 1ns/1ps
`default_nettype none
module symbol_quality_output_gate_bench import sqg_pkg::*;;
    // ****************************************
    // Signals
    // ****************************************
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        grade_vld = 1'b0;
    logic        grade_dpm = 1'b0;
    logic        grade_sym_ok = 1'b0;
    logic [7:0]  grade_ppe = 8'h00;
    logic [19:0] grade_vec = 20'h0_0000;
    logic        qual_out;
    logic [9:0]  fail_vec;
    logic        irq;
    logic [15:0] alarm_cnt;
    logic [31:0] d;
    int          fail_count = 0;
    int          n_tests = 0;

    always #2.5 mclk = ~mclk;

    sqg_gate uut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .grade_vld(grade_vld),
        .grade_dpm(grade_dpm), .grade_sym_ok(grade_sym_ok),
        .grade_ppe(grade_ppe), .grade_vec(grade_vec),
        .qual_out(qual_out), .fail_vec(fail_vec), .irq(irq));
    sqg_monitor mon (.mclk(mclk), .reset(reset), .qual_out(qual_out),
        .alarm_cnt(alarm_cnt));

    // ****************************************
    // Bus, grading and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic grd(input logic dp, input logic ok, input logic [7:0] p,
                       input logic [19:0] v);
        @(posedge mclk);
        grade_vld <= 1'b1;
        grade_dpm <= dp;
        grade_sym_ok <= ok;
        grade_ppe <= p;
        grade_vec <= v;
        @(posedge mclk);
        grade_vld <= 1'b0;
        grade_vec <= ~v;
        #1;
    endtask
    // All metrics grade A except metric i
    function automatic logic [19:0] gv(input int i, input logic [1:0] g);
        logic [19:0] v;
        v = 20'hf_ffff;
        v[2*i +: 2] = g;
        return v;
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(ADDR_LIN_EN);
        chk(d, 32'h0000_0000);
        rd(ADDR_LIN_THR);
        chk(d, 32'h000a_aaaa);
        rd(ADDR_DPM_EN);
        chk(d, 32'h0000_0000);
        rd(ADDR_DPM_THR);
        chk(d, 32'h0000_2aaa);
        grd(1'b0, 1'b1, 8'h28, 20'h0_0000);
        chk({31'h0, qual_out}, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_lin;
        logic [15:0] c0;
        c0 = alarm_cnt;
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_LIN_EN, 32'h1 << i);
            grd(1'b0, 1'b1, 8'h32, gv(i, 2'h1));
            chk({31'h0, qual_out}, 32'h0000_0001);
            chk({22'h0, fail_vec}, 32'h1 << i);
            grd(1'b0, 1'b1, 8'h32, gv(i, 2'h2));
            chk({31'h0, qual_out}, 32'h0000_0000);
        end
        chk({16'h0, alarm_cnt - c0}, 32'h0000_000a);
        $display("test linear set done");
    endtask
    task automatic t_codes;
        wr(ADDR_LIN_EN, 32'h0000_0001);
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_LIN_THR, 32'h000a_aaa8 | t);
            for (int g = 0; g < 4; g++) begin
                grd(1'b0, 1'b1, 8'h28, gv(0, g[1:0]));
                chk({31'h0, qual_out}, (g < t) ? 32'h1 : 32'h0);
            end
        end
        $display("test grade codes done");
    endtask
    task automatic t_dpm;
        wr(ADDR_DPM_EN, 32'h0000_007f);
        for (int i = 0; i < 7; i++) begin
            grd(1'b1, 1'b1, 8'h3c, gv(i, 2'h1) & 20'h0_3fff);
            chk({22'h0, fail_vec}, 32'h1 << i);
        end
        rd(ADDR_RESULT);
        chk(d, 32'h0003_0040);
        $display("test part-mark set done");
    endtask
    task automatic t_elig;
        wr(ADDR_INT_STAT, 32'h0000_0007);
        wr(ADDR_DPM_EN, 32'h0000_0001);
        grd(1'b0, 1'b1, 8'h28, gv(0, 2'h1));
        chk({31'h0, qual_out}, 32'h0000_0001);
        grd(1'b0, 1'b1, 8'h27, 20'hf_ffff);
        chk({31'h0, qual_out}, 32'h0000_0001);
        grd(1'b0, 1'b0, 8'h63, 20'hf_ffff);
        chk({31'h0, qual_out}, 32'h0000_0001);
        grd(1'b1, 1'b1, 8'h3b, 20'hf_ffff);
        chk({31'h0, qual_out}, 32'h0000_0001);
        grd(1'b1, 1'b1, 8'h3c, 20'hf_ffff);
        chk({31'h0, qual_out}, 32'h0000_0000);
        rd(ADDR_INT_STAT);
        chk(d, 32'h0000_0007);
        $display("test eligibility done");
    endtask
    task automatic t_irq;
        wr(ADDR_INT_STAT, 32'h0000_0007);
        wr(ADDR_INT_MASK, 32'h0000_0001);
        grd(1'b0, 1'b1, 8'h28, 20'hf_ffff);
        chk({31'h0, irq}, 32'h0000_0000);
        grd(1'b0, 1'b1, 8'h28, gv(0, 2'h0));
        chk({31'h0, irq}, 32'h0000_0001);
        wr(ADDR_INT_STAT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(ADDR_INT_STAT);
        chk(d, 32'h0000_0002);
        wr(8'h24, 32'h0000_0000);
        rd(8'h20);
        chk(d, 32'h0000_0000);
        rd(ADDR_LIN_EN);
        chk(d, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_LIN_THR);
        chk(d, 32'h000a_aaaa);
        rd(ADDR_DPM_EN);
        chk(d, 32'h0000_0000);
        $display("test interrupt and defaults done");
    endtask
    task automatic t_dflt;
        wr(ADDR_LIN_EN, 32'h0000_03ff);
        wr(ADDR_DPM_THR, 32'h0000_0000);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= ADDR_CTRL;
        reg_wdata <= 32'h0000_0001;
        @(posedge mclk);
        reg_wr <= 1'b0;
        grade_vld <= 1'b1;
        grade_dpm <= 1'b0;
        grade_sym_ok <= 1'b1;
        grade_ppe <= 8'h28;
        grade_vec <= 20'h0_0000;
        @(posedge mclk);
        grade_vld <= 1'b0;
        #1 chk({31'h0, qual_out}, 32'h0000_0000);
        rd(ADDR_DPM_THR);
        chk(d, 32'h0000_2aaa);
        $display("test default load done");
    endtask
    task automatic t_rerun;
        wr(ADDR_LIN_EN, 32'h0000_0001);
        grd(1'b0, 1'b1, 8'h28, gv(0, 2'h0));
        chk({31'h0, irq}, 32'h0000_0001);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1 chk({20'h0, irq, qual_out, fail_vec}, 32'h0000_0000);
        rd(ADDR_LIN_EN);
        chk(d, 32'h0000_0000);
        @(posedge mclk);
        #1 chk(reg_rdata, 32'h0000_0000);
        $display("test reset in run done");
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_lin();
        t_codes();
        t_dpm();
        t_elig();
        t_irq();
        t_dflt();
        t_rerun();
        complete_run();
    end

    // Watchdog well past the expected run length
    initial begin
        #20000;
        fail_count++;
        $display("CHECK FAILED %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
